// ===== boundary_run_20bit_test_and_tap_timing_tb.sv
`timescale 1ns/1ps
`default_nettype none
module boundary_run_20bit_test_and_tap_timing_tb;
	import boundary_run_pkg::*;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	logic mclk, resetn, ab_n, ba_n, tck, tms, tdi, tdo, tdo_oe, a_oe, b_oe, seen;
	logic [19:0] a_in, b_in, a_out, b_out; // pin levels and test drive
	wire logic tdo_pin; // what the controller sees on the wire
	int n_fail, checks;
	assign tdo_pin = tdo_oe ? tdo : 1'bz; // released driver floats
	boundary_run_tap #(.CELLS(CELL_WIDTH)) i_boundary_run_tap (.mclk(mclk), .resetn(resetn),
		.tck(tck), .tms(tms), .tdi(tdi), .a_to_b_output_enable_n(ab_n),
		.b_to_a_output_enable_n(ba_n), .a_in(a_in), .b_in(b_in), .tdo(tdo), .tdo_oe(tdo_oe),
		.a_out(a_out), .a_out_oe(a_oe), .b_out(b_out), .b_out_oe(b_oe));
	tap_controller_model i_tap_controller_model (.tck(tck), .tms(tms), .tdi(tdi),
		.tdo_pin(tdo_pin));
	// ----------------------------------------
	// shared helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [19:0] got, input logic [19:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic step(input logic m, input logic d);
		i_tap_controller_model.pulse(m, d, seen);
	endtask : step
	// scan from idle back to idle; q holds tdo bits in shift order, z0/z1 the wire
	// just before the first and just after the last shift
	task automatic scan(input bit ir, input int n, input logic [39:0] d, output logic [39:0] q,
		output logic z0, output logic z1);
		q = '0;
		step(1'b1, 1'b0);
		if (ir) begin
			step(1'b1, 1'b0);
		end
		step(1'b0, 1'b0);
		step(1'b0, 1'b0);
		z0 = seen;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, d[i]); // tms rises with the last bit
			q[i] = seen;
		end
		step(1'b1, 1'b0);
		z1 = seen;
		step(1'b0, 1'b0);
	endtask : scan
	// expected next pin value for a control code; other codes leave the pins alone
	function automatic logic [19:0] advance(input logic [2:0] code, input logic [19:0] v);
		if (code == BCR_SIG_RANDOM) begin
			return {v[18:0], v[FEEDBACK_HI] ^ v[FEEDBACK_LO]};
		end
		if (code == BCR_SIG_COUNT) begin
			return v + 20'h1;
		end
		return v;
	endfunction : advance
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic test_ir;
		logic [39:0] q;
		logic z0, z1;
		scan(1'b1, 8, {32'h0, IR_BYPASS}, q, z0, z1);
		check("ir capture", q[19:0], {12'h0, IR_CAPTURE_VALUE});
		check("tdo before shift", {19'h0, z0}, {19'h0, 1'bz});
		check("tdo after exit", {19'h0, z1}, {19'h0, 1'bz});
		scan(1'b0, 4, 40'hb, q, z0, z1);
		check("bypass path", q[19:0], 20'h6);
		$display("test_ir done");
	endtask : test_ir
	// program control code, seed, run instruction, then watch the output side in idle
	task automatic test_run(input logic [2:0] code, input logic eab, input logic eba,
		input logic [19:0] seed);
		logic [39:0] q;
		logic z0, z1, want_oe;
		logic [19:0] seq [12];
		logic [19:0] e;
		@(negedge mclk);
		ab_n = eab;
		ba_n = eba;
		scan(1'b1, 8, {32'h0, IR_CONTROL_SCAN}, q, z0, z1);
		scan(1'b0, 3, {37'h0, code}, q, z0, z1);
		scan(1'b1, 8, {32'h0, IR_BOUNDARY_SCAN}, q, z0, z1);
		scan(1'b0, 40, {seed, 20'h0}, q, z0, z1); // seed before the run
		scan(1'b1, 8, {32'h0, IR_BOUNDARY_RUN}, q, z0, z1);
		for (int k = 0; k < 12; k++) begin
			step(1'b0, 1'b0);
			seq[k] = eab ? a_out : b_out;
		end
		want_oe = eab != eba;
		check("output enable", {19'h0, eab ? a_oe : b_oe}, {19'h0, want_oe});
		e = seed;
		if (want_oe) begin
			// the first fall in idle shows the seed, each later fall one step on
			for (int k = 0; k < 12; k++) begin
				check("pattern on pins", seq[k], e);
				e = advance(code, e);
			end
		end else begin
			// no single direction: the shadow keeps the seed, nothing advances
			check("pins hold seed", seq[11], e);
		end
		$display("test_run code %h done", code);
	endtask : test_run
	// ----------------------------------------
	// clock, sequence, verdict
	// ----------------------------------------
	task automatic stop_test;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		resetn = 1'b0;
		ab_n = 1'b0;
		ba_n = 1'b1;
		a_in = 20'h5a5a5;
		b_in = 20'h3c3c3;
		n_fail = 0;
		checks = 0;
		repeat (5) @(negedge mclk);
		resetn = 1'b1;
		repeat (8) @(negedge mclk);
		#3.7; // keep tck off the mclk grid
		step(1'b0, 1'b0); // leave reset into idle
		test_ir();
		test_run(BCR_SIG_RANDOM, 1'b0, 1'b1, 20'h00001);
		test_run(BCR_SIG_RANDOM, 1'b0, 1'b1, 20'h00000);
		test_run(BCR_SIG_COUNT, 1'b1, 1'b0, 20'hffffe);
		test_run(3'h1, 1'b1, 1'b0, 20'h12345);
		test_run(BCR_SIG_COUNT, 1'b0, 1'b0, 20'h00010);
		stop_test();
	end
	// about 600 tck periods are expected; allow four times that
	initial begin
		#500000;
		n_fail++;
		stop_test();
	end
endmodule : boundary_run_20bit_test_and_tap_timing_tb
`default_nettype wire

// ===== boundary_run_pkg.sv
// Contract
// - input cells compress 20-bit signature each TCK rise
// - output cells advance pattern, drive on fall
// - all-zero seed keeps pattern stuck at zero
// - count mode increments outputs, drive on fall
// - test logic clocked by TCK, sampled on rise
// - TDO and test outputs change only on fall
// - instruction capture loads 10000001 leaving Capture-IR
// - TDO driver on at fall after shift entry
// - one instruction bit per rise in Shift-IR
// - TDO released on fall in Exit1 states
// - Update-IR fall loads the active instruction
// - all-ones instruction decodes as bypass
// - control codes 011 random, 111 count
// - run only under run instruction in Run-Test/Idle
// - run only with one direction enabled
package boundary_run_pkg;

	// ----------------------------------------
	// instruction register
	// ----------------------------------------
	localparam int IR_WIDTH = 8; // instruction length
	localparam logic [7:0] IR_CAPTURE_VALUE = 8'h81; // fixed capture pattern
	localparam logic [7:0] IR_BYPASS = 8'hff; // bypass instruction
	localparam logic [7:0] IR_BOUNDARY_RUN = 8'h09; // boundary run instruction
	localparam logic [7:0] IR_CONTROL_SCAN = 8'h0f; // control register scan
	localparam logic [7:0] IR_BOUNDARY_SCAN = 8'h03; // boundary register scan
	localparam logic [7:0] IR_RESET_VALUE = 8'hff; // active instruction after reset

	// ----------------------------------------
	// boundary control register
	// ----------------------------------------
	localparam int BCR_WIDTH = 3; // opcode bits 2..0
	localparam logic [2:0] BCR_SIG_RANDOM = 3'h3; // signature with random pattern
	localparam logic [2:0] BCR_SIG_COUNT = 3'h7; // signature with count up
	localparam logic [2:0] BCR_RESET_VALUE = 3'h0; // control value after reset

	// ----------------------------------------
	// boundary cells and feedback
	// ----------------------------------------
	localparam int CELL_WIDTH = 20; // cells per direction group
	localparam int FEEDBACK_HI = 19; // x^20 term
	localparam int FEEDBACK_LO = 16; // x^17 term, maximal length with x^20

	// ----------------------------------------
	// tap controller states
	// ----------------------------------------
	typedef enum logic [3:0] {
		test_logic_reset = 4'h0,
		run_idle = 4'h1,
		select_dr = 4'h3,
		capture_dr = 4'h2,
		shift_dr = 4'h6,
		exit1_dr = 4'h7,
		pause_dr = 4'h5,
		exit2_dr = 4'h4,
		update_dr = 4'hc,
		select_ir = 4'hd,
		capture_ir = 4'hf,
		shift_ir = 4'he,
		exit1_ir = 4'ha,
		pause_ir = 4'hb,
		exit2_ir = 4'h9,
		update_ir = 4'h8
	} tap_state_t;

endpackage : boundary_run_pkg

// ===== boundary_run_tap.sv
`timescale 1ns/1ps
`default_nettype none
module boundary_run_tap
	import boundary_run_pkg::*;
#(
	parameter int CELLS = CELL_WIDTH // cells per direction group
) (
	input wire logic mclk, // system clock
	input wire logic resetn, // synchronous reset, active low
	input wire logic tck, // test clock pin
	input wire logic tms, // test mode select pin
	input wire logic tdi, // test data in pin
	input wire logic a_to_b_output_enable_n, // a to b enable pin, low active
	input wire logic b_to_a_output_enable_n, // b to a enable pin, low active
	input wire logic [CELLS-1:0] a_in, // a side pin levels
	input wire logic [CELLS-1:0] b_in, // b side pin levels
	output logic tdo, // test data out
	output logic tdo_oe, // tdo driver enable
	output logic [CELLS-1:0] a_out, // test data for a pins
	output logic a_out_oe, // test drive of a pins
	output logic [CELLS-1:0] b_out, // test data for b pins
	output logic b_out_oe // test drive of b pins
);

	// ----------------------------------------
	// helper functions
	// ----------------------------------------
	// standard tap transition table
	function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
		unique case (s)
			test_logic_reset: tap_next = m ? test_logic_reset : run_idle;
			run_idle: tap_next = m ? select_dr : run_idle;
			select_dr: tap_next = m ? select_ir : capture_dr;
			capture_dr: tap_next = m ? exit1_dr : shift_dr;
			shift_dr: tap_next = m ? exit1_dr : shift_dr;
			exit1_dr: tap_next = m ? update_dr : pause_dr;
			pause_dr: tap_next = m ? exit2_dr : pause_dr;
			exit2_dr: tap_next = m ? update_dr : shift_dr;
			update_dr: tap_next = m ? select_dr : run_idle;
			select_ir: tap_next = m ? test_logic_reset : capture_ir;
			capture_ir: tap_next = m ? exit1_ir : shift_ir;
			shift_ir: tap_next = m ? exit1_ir : shift_ir;
			exit1_ir: tap_next = m ? update_ir : pause_ir;
			pause_ir: tap_next = m ? exit2_ir : pause_ir;
			exit2_ir: tap_next = m ? update_ir : shift_ir;
			update_ir: tap_next = m ? select_dr : run_idle;
		endcase
	endfunction : tap_next

	// opcode bits 2..0 name one of the two combined operations
	function automatic logic is_run_code(input logic [2:0] code);
		is_run_code = (code == BCR_SIG_RANDOM) || (code == BCR_SIG_COUNT);
	endfunction : is_run_code

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [4:0] pin_s1; // first stage, read only by second stage
	logic [4:0] pin_s2; // tck, tms, tdi, enables
	logic [CELLS-1:0] a_s1, a_s2; // a pins
	logic [CELLS-1:0] b_s1, b_s2; // b pins
	logic tck_d; // previous tck level

	// two flops on every pin, the tck edge is found on the second stage
	always_ff @(posedge mclk) begin
		pin_s1 <= {tck, tms, tdi, a_to_b_output_enable_n, b_to_a_output_enable_n};
		pin_s2 <= pin_s1;
		a_s1 <= a_in;
		a_s2 <= a_s1;
		b_s1 <= b_in;
		b_s2 <= b_s1;
		tck_d <= resetn ? pin_s2[4] : 1'b0;
	end

	wire logic tck_rise = pin_s2[4] & ~tck_d;
	wire logic tck_fall = ~pin_s2[4] & tck_d;
	wire logic tms_s = pin_s2[3]; // sampled tms
	wire logic tdi_s = pin_s2[2]; // sampled tdi
	wire logic dir_ab = ~pin_s2[1] & pin_s2[0]; // a inputs, b outputs
	wire logic dir_ba = pin_s2[1] & ~pin_s2[0]; // b inputs, a outputs

	// ----------------------------------------
	// tap controller
	// ----------------------------------------
	tap_state_t tap_state; // current tap state

	// the controller moves only on a sampled rising tck
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			tap_state <= test_logic_reset;
		end else if (tck_rise) begin
			tap_state <= tap_next(tap_state, tms_s);
		end
	end

	// ----------------------------------------
	// instruction register
	// ----------------------------------------
	logic [IR_WIDTH-1:0] ir_shift; // capture and shift stage
	logic [IR_WIDTH-1:0] active_instr; // instruction in force

	// capture and shift on rise
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ir_shift <= IR_RESET_VALUE;
		end else if (tck_rise && tap_state == capture_ir) begin
			ir_shift <= IR_CAPTURE_VALUE;
		end else if (tck_rise && tap_state == shift_ir) begin
			ir_shift <= {tdi_s, ir_shift[IR_WIDTH-1:1]};
		end
	end

	// update on fall; reset state forces bypass back in
	always_ff @(posedge mclk) begin
		if (!resetn || tap_state == test_logic_reset) begin
			active_instr <= IR_RESET_VALUE;
		end else if (tck_fall && tap_state == update_ir) begin
			active_instr <= ir_shift;
		end
	end

	// unknown codes, the run code and all ones fall back to the bypass bit
	wire logic sel_boundary = (active_instr == IR_BOUNDARY_SCAN); // boundary in path
	wire logic sel_control = (active_instr == IR_CONTROL_SCAN); // control in path
	wire logic sel_bypass = !sel_boundary && !sel_control;

	// ----------------------------------------
	// bypass and control registers
	// ----------------------------------------
	logic bypass_bit; // one bit bypass register
	logic [BCR_WIDTH-1:0] bcr_shift; // control shift stage
	logic [BCR_WIDTH-1:0] boundary_control_register; // selected operation

	// bypass captures zero, shifts tdi
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			bypass_bit <= 1'b0;
		end else if (tck_rise && sel_bypass && tap_state == capture_dr) begin
			bypass_bit <= 1'b0;
		end else if (tck_rise && sel_bypass && tap_state == shift_dr) begin
			bypass_bit <= tdi_s;
		end
	end

	// control register keeps its value on capture, loads on update-dr fall
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			bcr_shift <= BCR_RESET_VALUE;
			boundary_control_register <= BCR_RESET_VALUE;
		end else if (sel_control) begin
			if (tck_rise && tap_state == capture_dr) begin
				bcr_shift <= boundary_control_register;
			end else if (tck_rise && tap_state == shift_dr) begin
				bcr_shift <= {tdi_s, bcr_shift[BCR_WIDTH-1:1]};
			end
			if (tck_fall && tap_state == update_dr) begin
				boundary_control_register <= bcr_shift;
			end
		end
	end

	// ----------------------------------------
	// boundary cells and run operations
	// ----------------------------------------
	logic [CELLS-1:0] in_cells; // input mode cells, hold signature
	logic [CELLS-1:0] out_cells; // output mode cells, hold pattern
	logic [CELLS-1:0] shadow; // shadow latches of output cells
	logic [CELLS-1:0] next_shadow; // shadow after this cycle, also fed to the pins
	logic [CELLS-1:0] next_signature; // signature after one more rise
	wire logic [CELLS-1:0] in_pins = dir_ab ? a_s2 : b_s2; // pins read as inputs

	// the run needs the run code, idle state and exactly one direction
	wire logic run_ok = (active_instr == IR_BOUNDARY_RUN) && (tap_state == run_idle)
		&& (dir_ab != dir_ba) && is_run_code(boundary_control_register);
	wire logic run_rise = run_ok && tck_rise; // one run step
	wire logic count_mode = (boundary_control_register == BCR_SIG_COUNT); // count up

	// xor feedback with the pin levels mixed in, so an all zero signature leaves zero once a pin is high
	always_comb begin
		next_signature = {in_cells[CELLS-2:0], in_cells[FEEDBACK_HI] ^ in_cells[FEEDBACK_LO]}
			^ in_pins;
	end

	// input cells: capture, scan, or signature compression
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			in_cells <= '0;
		end else if (run_rise) begin
			in_cells <= next_signature;
		end else if (tck_rise && sel_boundary && tap_state == capture_dr) begin
			in_cells <= in_pins;
		end else if (tck_rise && sel_boundary && tap_state == shift_dr) begin
			in_cells <= {out_cells[0], in_cells[CELLS-1:1]};
		end
	end

	// output cells: scan, random pattern or count; seed comes from the scan
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			out_cells <= '0;
		end else if (run_rise && count_mode) begin
			out_cells <= out_cells + {{(CELLS-1){1'b0}}, 1'b1};
		end else if (run_rise) begin
			out_cells <= {out_cells[CELLS-2:0],
				out_cells[FEEDBACK_HI] ^ out_cells[FEEDBACK_LO]};
		end else if (tck_rise && sel_boundary && tap_state == shift_dr) begin
			out_cells <= {tdi_s, out_cells[CELLS-1:1]};
		end
	end

	// shadow latches follow the cells on falling edges only; the pins take the
	// same value at that same fall, so the pins never trail the shadow
	always_comb begin
		next_shadow = shadow;
		if (tck_fall && (run_ok || (sel_boundary && tap_state == update_dr))) begin
			next_shadow = out_cells;
		end
	end

	// shadow register
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			shadow <= '0;
		end else begin
			shadow <= next_shadow;
		end
	end

	// ----------------------------------------
	// pin drive and tdo
	// ----------------------------------------
	// test drive of the output side is settled on falling edges only
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			a_out <= '0;
			b_out <= '0;
			a_out_oe <= 1'b0;
			b_out_oe <= 1'b0;
		end else if (tck_fall) begin
			a_out <= next_shadow;
			b_out <= next_shadow;
			a_out_oe <= (active_instr == IR_BOUNDARY_RUN) && dir_ba;
			b_out_oe <= (active_instr == IR_BOUNDARY_RUN) && dir_ab;
		end
	end

	// tdo presents the path lsb and its driver on falling edges
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (tck_fall) begin
			tdo_oe <= (tap_state == shift_ir) || (tap_state == shift_dr);
			if (tap_state == shift_ir) begin
				tdo <= ir_shift[0];
			end else if (tap_state == shift_dr) begin
				tdo <= sel_boundary ? in_cells[0] : (sel_control ? bcr_shift[0] : bypass_bit);
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	AST_TAP_MOVES_ON_RISE: assert property (
		!$stable(tap_state) |-> $past(tck_rise) || !$past(resetn)
	) else $error("tap state moved without a tck rise");

	AST_TDO_ON_FALL: assert property (
		(!$stable(tdo) || !$stable(tdo_oe) || !$stable(b_out_oe)) |-> $past(tck_fall)
	) else $error("tdo or pin drive changed without a tck fall");

	AST_IR_CAPTURE: assert property (
		(tck_rise && tap_state == capture_ir) |=> (ir_shift == 8'h81)
	) else $error("instruction capture value wrong");

	AST_IR_SHIFT_ONE_BIT: assert property (
		(tck_rise && tap_state == shift_ir)
			|=> (ir_shift == {$past(tdi_s), $past(ir_shift[7:1])}) ##1 $stable(ir_shift)[*3]
	) else $error("instruction shift step wrong");

	AST_TDO_ENABLE: assert property (
		(tck_fall && (tap_state == shift_ir || tap_state == shift_dr)) |=> tdo_oe
	) else $error("tdo driver not enabled in shift");

	AST_TDO_RELEASE: assert property (
		(tck_fall && (tap_state == exit1_ir || tap_state == exit1_dr)) |=> !tdo_oe
	) else $error("tdo driver not released in exit1");

	AST_IR_UPDATE: assert property (
		(tck_fall && tap_state == update_ir) |=> (active_instr == $past(ir_shift))
	) else $error("active instruction not updated");

	AST_BYPASS_SHIFT: assert property (
		(tck_rise && tap_state == shift_dr && active_instr == 8'hff)
			|=> (bypass_bit == $past(tdi_s))
	) else $error("bypass bit did not take tdi");

	AST_SIGNATURE: assert property (
		run_rise |=> (in_cells == ({$past(in_cells[18:0]), $past(in_cells[19]) ^ $past(in_cells[16])}
			^ $past(in_pins)))
	) else $error("signature not compressed on run step");

	AST_ZERO_SEED_STUCK: assert property (
		(run_rise && boundary_control_register == 3'h3 && out_cells == '0) |=> (out_cells == '0)
	) else $error("zero seed left zero");

	AST_COUNT_UP: assert property (
		(run_rise && boundary_control_register == 3'h7) |=> (out_cells == $past(out_cells) + 1'b1)
	) else $error("count did not advance by one");

	AST_PATTERN_TO_SHADOW: assert property (
		(tck_fall && run_ok) |=> (shadow == $past(out_cells)) ##1 (tck_fall || shadow == b_out || !b_out_oe)
	) else $error("pattern not latched on fall");

	AST_NO_RUN_BOTH_DIRS: assert property (
		(tck_rise && tap_state == run_idle && dir_ab == dir_ba) |=> $stable(out_cells)
	) else $error("run step without a single direction");

	AST_RUN_ONLY_IDLE: assert property (
		(tck_rise && tap_state != run_idle && tap_state != shift_dr) |=> $stable(out_cells)
	) else $error("output cells moved outside idle or shift");

endmodule : boundary_run_tap
`default_nettype wire

// ===== tap_controller_model.sv
`timescale 1ns/1ps
`default_nettype none
module tap_controller_model (
	output var logic tck, // test clock, stands low between calls
	output var logic tms, // mode select
	output var logic tdi, // serial data into the device
	input wire logic tdo_pin // resolved tdo wire, z when released
);
	// ----------------------------------------
	// idle levels
	// ----------------------------------------
	// tms high keeps the tap parked in test logic reset until we move it
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// one 200 ns tck period starting just after a fall
	// tdo is read late in the high half because the device only moves it some mclk after a fall
	task automatic pulse(input logic m, input logic d, output logic seen);
		tms = m; // changed only after a fall, before the rise
		tdi = d;
		#100 tck = 1'b1;
		#95 seen = tdo_pin;
		#5 tck = 1'b0;
	endtask : pulse
endmodule : tap_controller_model
`default_nettype wire
